/* File: rtl/sfr_pkg.sv */
// Constants shared by the sensor fault response unit and its EEPROM check.
// Assumes a single 25 MHz clock and APB register access with 32-bit words.
package sfr_pkg;
  // Clock
  localparam int CLK_NS = 40;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0c;
  localparam logic [7:0] ADDR_EERD   = 8'h10;

  // Configuration register fields
  localparam int CFG_DIAG_MODE = 0;
  localparam int CFG_MODE_LO   = 1;   // Output mode, two bits
  localparam int CFG_UV_DIS    = 3;
  localparam int CFG_OV_DIS    = 4;
  localparam int CFG_OT_DIS    = 5;
  localparam int CFG_OOR_DIS   = 6;
  localparam int CFG_COIL_DIS  = 7;
  localparam int CFG_LBIST_DIS = 8;
  localparam int CFG_LOCK_LO   = 9;   // Lock code, three bits
  localparam int CFG_W         = 12;
  localparam logic [11:0] CFG_RST = 12'h000;

  // Output modes
  localparam logic [1:0] MODE_PWM  = 2'h0;
  localparam logic [1:0] MODE_SENT = 2'h1;
  localparam logic [1:0] MODE_TRIG = 2'h2;

  // Lock codes that count as locked
  localparam logic [2:0] LOCK_A = 3'h3;
  localparam logic [2:0] LOCK_B = 3'h5;
  localparam logic [2:0] LOCK_C = 3'h6;

  // Timing register reset values, in clock cycles
  localparam logic [15:0] FRAME_CYC_RST = 16'h03e8;
  localparam logic [15:0] TICK_CYC_RST  = 16'h004b;

  // Command register
  localparam int CMD_SELFTEST = 0;

  // Status register fields
  localparam int ST_DIAG_LO = 8;
  localparam int ST_SCN_LO  = 16;
  localparam int ST_PROG    = 18;
  localparam int ST_HIZ     = 19;
  localparam int ST_BUSY    = 20;
  localparam int ST_QUIET   = 21;

  // Fault status bit positions
  localparam int FLT_EEDBE = 0;
  localparam int FLT_LBIST = 1;
  localparam int FLT_COIL  = 2;
  localparam int FLT_UV    = 3;
  localparam int FLT_OV    = 4;
  localparam int FLT_OT    = 5;
  localparam int FLT_OORL  = 6;
  localparam int FLT_OORH  = 7;

  // SENT diagnostic field positions
  localparam int DG_OORH = 0;
  localparam int DG_OORL = 1;
  localparam int DG_OT   = 2;
  localparam int DG_OV   = 3;
  localparam int DG_UV   = 4;
  localparam int DG_COIL = 5;

  // SENT status nibble bits
  localparam int SCN_COIL = 0;
  localparam int SCN_ANY  = 1;

  // PWM fault duty cycles in percent
  localparam logic [6:0] DUTY_OV   = 7'd60;
  localparam logic [6:0] DUTY_UV   = 7'd40;
  localparam logic [6:0] DUTY_COIL = 7'd30;
  localparam logic [6:0] DUTY_OT   = 7'd70;
  localparam logic [6:0] DUTY_OORL = 7'd80;
  localparam logic [6:0] DUTY_OORH = 7'd90;

  // Self-test request lengths
  localparam logic [3:0] DREQ_FRAMES = 4'd2;
  localparam logic [3:0] DREQ_TICKS  = 4'd15;

  // Triggered SENT timing
  localparam int TRG_MIN_NS = 1800;
  localparam logic [15:0] TRG_CYC = 16'((TRG_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] SYNC_MIN_TICKS = 10'd7;
  localparam logic [9:0] SYNC_MAX_TICKS = 10'd524;
  localparam logic [6:0] SYNC_LEN_TICKS = 7'd56;
  localparam int SCN_GAP_NS = 70000;
  localparam logic [23:0] SCN_GAP_CYC = 24'((SCN_GAP_NS + CLK_NS - 1) / CLK_NS);

  // Long delays
  localparam int DIAG_MIN_MS = 10;
  localparam int DIAG_CYC    = DIAG_MIN_MS * 1000000 / CLK_NS;
  localparam int PO_US       = 1000;
  localparam int PO_CYC      = PO_US * 1000 / CLK_NS;

  // Pin input indices, synchronised as one vector
  localparam int PIN_POR   = 0;
  localparam int PIN_UVL   = 1;
  localparam int PIN_UVH   = 2;
  localparam int PIN_OVH   = 3;
  localparam int PIN_OVL   = 4;
  localparam int PIN_HV    = 5;
  localparam int PIN_OT    = 6;
  localparam int PIN_GND   = 7;
  localparam int PIN_COIL  = 8;
  localparam int PIN_CLPL  = 9;
  localparam int PIN_CLPH  = 10;
  localparam int PIN_ADCL  = 11;
  localparam int PIN_ADCH  = 12;
  localparam int PIN_LINE  = 13;
  localparam int PIN_W     = 14;

  // EEPROM read response bits
  localparam int EE_DATA_W = 26;
  localparam int EE_SBE    = 28;
  localparam int EE_DBE    = 29;

  typedef enum logic {ST_IDLE, ST_RUN} sfr_test_t;
  typedef enum logic [1:0] {TR_IDLE, TR_LOW, TR_WAIT} sfr_trig_t;
endpackage

/* File: rtl/sfr_ecc.sv */
// Single-error-correct, double-error-detect check on one stored word.
// Assumes a 32-bit word: Hamming bits at positions 1..31, overall parity at 0.
`timescale 1ns/1ps
module sfr_ecc
  import sfr_pkg::*;
(
  input  wire logic [31:0]          word_i,  // Raw stored word
  output logic      [EE_DATA_W-1:0] data_o,  // Corrected contents
  output logic                      sbe_o,   // Single error corrected
  output logic                      dbe_o    // Double error seen
);
  // Syndrome, correction and data extraction in one pass
  always_comb begin
    logic [4:0]  syn;
    logic        par;
    logic [31:0] fix;
    int          j;
    syn = 5'h00;
    par = ^word_i;
    j   = 0;
    fix = word_i;
    for (int p = 1; p < 32; p++) begin
      if (word_i[p]) begin
        syn = syn ^ 5'(p);
      end
    end
    sbe_o  = 1'b0;
    dbe_o  = 1'b0;
    // Odd parity means one flip, even parity with syndrome means two
    if (par) begin
      fix[syn] = ~word_i[syn];
      sbe_o    = 1'b1;
    end else if (syn != 5'h00) begin
      dbe_o = 1'b1;
    end
    data_o = '0;
    for (int p = 3; p < 32; p++) begin
      if ((p & (p - 1)) != 0) begin
        data_o[j] = fix[p];
        j         = j + 1;
      end
    end
  end
endmodule

/* File: rtl/sfr_unit.sv */
// Fault detection and output response for the sensor's open-drain line.
// Assumes comparator levels arrive as asynchronous pins; the frame
// generator and EEPROM array run on clk_i.
//
// What this block does
// R1: Undervoltage forces fault state below low threshold, clears above high.
// R2: Below reset level hold line released; no normal data before quiet delay.
// R3: Overvoltage only when locked code 3/5/6, enabled, above upper threshold.
// R4: Unlocked with supply above overvoltage level: programming mode, released.
// R5: Supply above high-voltage threshold always releases the line.
// R6: Overtemperature raises fault when enabled and responds per configuration.
// R7: Lost ground switches the driver off.
// R8: Single errors corrected silently; double errors fault and release line.
// R9: Read response: data bits 0-25, bit 28 corrected, bit 29 double error.
// R10: Out-of-range low/high from clamping or converter overrange, gated.
// R11: PWM mode 0: overvoltage 60%, undervoltage 40% at half carrier.
// R12: PWM mode 0: analog self-check 30%, overtemperature 70% at half carrier.
// R13: PWM mode 0: out-of-range low 80%, high 90% at half carrier.
// R14: SENT status bit 0 analog check; bit 1 any other coded fault.
// R15: PWM mode 1 releases line on any fault; not used with SENT.
// R16: Self-test failure and double error release line, not in SENT data.
// R17: Fault status byte bit 7 down to 0 as listed.
// R18: SENT diagnostic byte maps faults to bits 5 down to 0.
// R19: Controller holds line low 2 frames (PWM) or 15 ticks (SENT).
// R20: Triggered SENT: trigger low at least 1.8 us; request after sync.
// R21: Sync starts 7..524 ticks after trigger, about 70 us to status.
// R22: Self-test takes 10 to 20 ms before output resumes.
// R23: Simultaneous PWM faults: one code by fixed priority, supply first.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module sfr_unit
  import sfr_pkg::*;
#(
  parameter int DIAG_CYCLES  = DIAG_CYC,  // Self-test run time
  parameter int QUIET_CYCLES = PO_CYC     // Power-up quiet delay
) (
  input  wire logic              clk_i,         // 25 MHz clock
  input  wire logic              rst_i,         // Async reset, active high
  input  wire logic              psel_i,        // APB select
  input  wire logic              penable_i,     // APB enable
  input  wire logic              pwrite_i,      // APB write
  input  wire logic [7:0]        paddr_i,       // APB byte address
  input  wire logic [31:0]       pwdata_i,      // APB write data
  output logic      [31:0]       prdata_o,      // APB read data
  output logic                   pready_o,      // APB ready
  output logic                   pslverr_o,     // APB error
  input  wire logic [PIN_W-2:0]  mon_i,         // Comparator pins
  input  wire logic              line_i,        // Sensed line level
  output logic                   line_o,        // Driven level, always low
  output logic                   line_oe_o,     // Pull line low
  input  wire logic              normal_low_i,  // Normal data pulls low
  input  wire logic [31:0]       ee_word_i,     // Stored word under check
  input  wire logic              lbist_err_i,   // Logic check mismatch
  output logic      [7:0]        fault_o,       // Fault status byte
  output logic      [7:0]        sent_diag_o,   // SENT diagnostic byte
  output logic      [1:0]        sent_scn_o,    // SENT status bits
  output logic                   sync_start_o,  // Triggered sync start
  output logic                   data_ok_o      // Normal data allowed
);
  logic [PIN_W-1:0] pin_a_reg, pin_s_reg, pin_raw;
  logic [CFG_W-1:0] cfg_reg;
  logic [15:0]      frame_cyc_reg, tick_cyc_reg;
  logic [15:0]      fcnt_reg, tcnt_reg;
  logic             frame_p, tick_p;
  logic             uv_reg, ov_reg, lbist_reg, dbe_reg;
  logic [31:0]      eerd_reg;
  logic [EE_DATA_W-1:0] ee_data;
  logic             ee_sbe, ee_dbe;
  logic [31:0]      quiet_reg;
  logic             quiet_done;
  sfr_test_t        test_reg;
  logic [31:0]      test_cnt_reg;
  logic [3:0]       req_cnt_reg;
  logic             st_req;
  sfr_trig_t        trig_reg;
  logic [23:0]      tr_cyc_reg;
  logic [9:0]       tr_ticks_reg;
  logic             trig_win_reg;
  logic [16:0]      wcnt_reg;
  logic [6:0]       duty;
  logic [16:0]      thr;
  logic [7:0]       flt;
  logic             coded, hiz, prog, locked, pwm, wr, rd;
  logic             line_s;

  // Two flip-flops on every asynchronous pin
  for (genvar i = 0; i < PIN_W; i++) begin : g_sync
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        pin_a_reg[i] <= 1'b0;
        pin_s_reg[i] <= 1'b0;
      end else begin
        pin_a_reg[i] <= pin_raw[i];
        pin_s_reg[i] <= pin_a_reg[i];
      end
    end
  end
  assign line_s  = pin_s_reg[PIN_LINE];
  assign pin_raw = {line_i, mon_i};  // Line level is the top bit

  // APB decode; every access completes in one access cycle
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & ~pwrite_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg       <= CFG_RST;
      frame_cyc_reg <= FRAME_CYC_RST;
      tick_cyc_reg  <= TICK_CYC_RST;
    end else if (wr && paddr_i == ADDR_CFG) begin
      cfg_reg <= pwdata_i[CFG_W-1:0];
    end else if (wr && paddr_i == ADDR_TIMING) begin
      frame_cyc_reg <= pwdata_i[15:0];
      tick_cyc_reg  <= pwdata_i[31:16];
    end
  end

  // Read mux and error answer for unmapped offsets
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        unique case (paddr_i)
          ADDR_CFG:    prdata_o <= {20'h00000, cfg_reg};
          ADDR_TIMING: prdata_o <= {tick_cyc_reg, frame_cyc_reg};
          ADDR_STATUS: prdata_o <= {10'h000, ~quiet_done, test_reg == ST_RUN, hiz, prog,
                                    sent_scn_o, sent_diag_o, fault_o};
          ADDR_CMD:    prdata_o <= 32'h0000_0000;
          ADDR_EERD:   prdata_o <= eerd_reg;
          default:     pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // Free-running frame and tick pulses from programmed periods
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fcnt_reg <= 16'h0000;
      tcnt_reg <= 16'h0000;
    end else begin
      fcnt_reg <= frame_p ? 16'h0000 : fcnt_reg + 16'h0001;
      tcnt_reg <= tick_p ? 16'h0000 : tcnt_reg + 16'h0001;
    end
  end
  assign frame_p = (fcnt_reg >= frame_cyc_reg - 16'h0001);
  assign tick_p  = (tcnt_reg >= tick_cyc_reg - 16'h0001);

  // EEPROM word check; response formed here for the bus
  sfr_ecc u_ecc (
    .word_i (ee_word_i),
    .data_o (ee_data),
    .sbe_o  (ee_sbe),
    .dbe_o  (ee_dbe)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eerd_reg <= 32'h0000_0000;
      dbe_reg  <= 1'b0;
    end else begin
      eerd_reg              <= {6'h00, ee_data};  // R9
      eerd_reg[EE_SBE]      <= ee_sbe;            // R9
      eerd_reg[EE_DBE]      <= ee_dbe;            // R9
      dbe_reg               <= ee_dbe;            // R8
    end
  end

  // Supply hysteresis: undervoltage set below low, clear only above high; overvoltage set above high, clear below low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uv_reg <= 1'b0;
      ov_reg <= 1'b0;
    end else begin
      if (pin_s_reg[PIN_UVL]) begin
        uv_reg <= 1'b1;                           // R1
      end else if (pin_s_reg[PIN_UVH]) begin
        uv_reg <= 1'b0;                           // R1
      end
      if (pin_s_reg[PIN_OVH]) begin
        ov_reg <= 1'b1;                           // R3
      end else if (pin_s_reg[PIN_OVL]) begin
        ov_reg <= 1'b0;                           // R3
      end
    end
  end

  assign locked = (cfg_reg[CFG_LOCK_LO +: 3] == LOCK_A) ||
                  (cfg_reg[CFG_LOCK_LO +: 3] == LOCK_B) ||
                  (cfg_reg[CFG_LOCK_LO +: 3] == LOCK_C);  // R3
  assign prog   = ~locked & ov_reg;                        // R4
  assign pwm    = cfg_reg[CFG_MODE_LO +: 2] == MODE_PWM;

  // Fault flags in status byte order; all but the double error gated
  always_comb begin
    flt            = 8'h00;
    flt[FLT_UV]    = uv_reg & ~cfg_reg[CFG_UV_DIS];                   // R1
    flt[FLT_OV]    = ov_reg & locked & ~cfg_reg[CFG_OV_DIS];          // R3
    flt[FLT_OT]    = pin_s_reg[PIN_OT] & ~cfg_reg[CFG_OT_DIS];        // R6
    flt[FLT_COIL]  = pin_s_reg[PIN_COIL] & ~cfg_reg[CFG_COIL_DIS];
    flt[FLT_OORL]  = (pin_s_reg[PIN_CLPL] | pin_s_reg[PIN_ADCL]) &
                     ~cfg_reg[CFG_OOR_DIS];                           // R10
    flt[FLT_OORH]  = (pin_s_reg[PIN_CLPH] | pin_s_reg[PIN_ADCH]) &
                     ~cfg_reg[CFG_OOR_DIS];                           // R10
    flt[FLT_LBIST] = lbist_reg & ~cfg_reg[CFG_LBIST_DIS];             // R16
    flt[FLT_EEDBE] = dbe_reg;                                         // R8
  end

  // Faults that have a PWM or SENT code
  assign coded = flt[FLT_UV] | flt[FLT_OV] | flt[FLT_OT] | flt[FLT_COIL] |
                 flt[FLT_OORL] | flt[FLT_OORH];

  // Conditions that release the line outright
  assign hiz = pin_s_reg[PIN_POR]                                    // R2
             | pin_s_reg[PIN_HV]                                     // R5
             | pin_s_reg[PIN_GND]                                    // R7
             | prog                                                  // R4
             | flt[FLT_EEDBE] | flt[FLT_LBIST]                       // R16
             | (test_reg == ST_RUN)                                  // R22
             | (pwm & cfg_reg[CFG_DIAG_MODE] & coded);               // R15

  // Quiet delay restarts on every reset event
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_reg <= 32'h0000_0000;
    end else if (pin_s_reg[PIN_POR]) begin
      quiet_reg <= 32'h0000_0000;                 // R2
    end else if (!quiet_done) begin
      quiet_reg <= quiet_reg + 32'h0000_0001;
    end
  end
  assign quiet_done = quiet_reg >= 32'(QUIET_CYCLES);  // R2

  // Self-test request: line held low by the controller, counted in
  // frames for PWM and ticks for SENT; any high sample restarts it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_cnt_reg <= 4'h0;
    end else if (line_s || test_reg == ST_RUN) begin
      req_cnt_reg <= 4'h0;
    end else if (pwm ? frame_p : (tick_p & (trig_win_reg |
                 cfg_reg[CFG_MODE_LO +: 2] != MODE_TRIG))) begin  // R20
      if (req_cnt_reg != 4'hf) begin
        req_cnt_reg <= req_cnt_reg + 4'h1;
      end
    end
  end
  assign st_req = (pwm && req_cnt_reg >= DREQ_FRAMES) ||
                  (!pwm && req_cnt_reg >= DREQ_TICKS);             // R19

  // Logic self-test run; the line stays released while it runs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      test_reg     <= ST_IDLE;
      test_cnt_reg <= 32'h0000_0000;
      lbist_reg    <= 1'b0;
    end else begin
      unique case (test_reg)
        ST_IDLE: begin
          test_cnt_reg <= 32'h0000_0000;
          if (!cfg_reg[CFG_LBIST_DIS] &&
              (st_req || (wr && paddr_i == ADDR_CMD && pwdata_i[CMD_SELFTEST]))) begin
            test_reg  <= ST_RUN;
            lbist_reg <= 1'b0;
          end
        end
        ST_RUN: begin
          test_cnt_reg <= test_cnt_reg + 32'h0000_0001;
          if (lbist_err_i) begin
            lbist_reg <= 1'b1;
          end
          if (test_cnt_reg >= 32'(DIAG_CYCLES) - 32'h0000_0001) begin
            test_reg <= ST_IDLE;                  // R22
          end
        end
      endcase
    end
  end

  // Triggered SENT: qualify trigger width, then place the sync pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_reg     <= TR_IDLE;
      tr_cyc_reg   <= 24'h000000;
      tr_ticks_reg <= 10'h000;
      trig_win_reg <= 1'b0;
      sync_start_o <= 1'b0;
    end else begin
      sync_start_o <= 1'b0;
      if (cfg_reg[CFG_MODE_LO +: 2] != MODE_TRIG) begin
        trig_reg     <= TR_IDLE;
        trig_win_reg <= 1'b0;
      end else begin
        unique case (trig_reg)
          TR_IDLE: begin
            tr_cyc_reg   <= 24'h000000;
            tr_ticks_reg <= 10'h000;
            if (!line_s && !line_oe_o && !trig_win_reg) begin
              trig_reg <= TR_LOW;
            end
            if (line_s) begin
              trig_win_reg <= 1'b0;
            end
          end
          TR_LOW: begin
            tr_cyc_reg <= tr_cyc_reg + 24'h000001;
            if (tick_p) begin
              tr_ticks_reg <= tr_ticks_reg + 10'h001;
            end
            if (line_s) begin
              // Too short a pulse is noise, not a trigger
              trig_reg <= (tr_cyc_reg >= 24'(TRG_CYC)) ? TR_WAIT : TR_IDLE;  // R20
            end
          end
          TR_WAIT: begin
            tr_cyc_reg <= tr_cyc_reg + 24'h000001;
            if (tick_p) begin
              tr_ticks_reg <= tr_ticks_reg + 10'h001;
            end
            if ((tr_ticks_reg >= SYNC_MIN_TICKS &&
                 tr_cyc_reg + 24'(SYNC_LEN_TICKS * tick_cyc_reg) >= SCN_GAP_CYC) ||
                tr_ticks_reg >= SYNC_MAX_TICKS) begin
              sync_start_o <= 1'b1;               // R21
              trig_win_reg <= 1'b1;
              trig_reg     <= TR_IDLE;
            end
          end
          default: trig_reg <= TR_IDLE;
        endcase
      end
    end
  end

  // One PWM fault code by priority, supply faults first
  always_comb begin
    if (flt[FLT_UV]) begin
      duty = DUTY_UV;                             // R11 R23
    end else if (flt[FLT_OV]) begin
      duty = DUTY_OV;                             // R11 R23
    end else if (flt[FLT_OT]) begin
      duty = DUTY_OT;                             // R12
    end else if (flt[FLT_COIL]) begin
      duty = DUTY_COIL;                           // R12
    end else if (flt[FLT_OORL]) begin
      duty = DUTY_OORL;                           // R13
    end else begin
      duty = DUTY_OORH;                           // R13
    end
    // Half carrier frequency: period is two frames
    thr = 17'(({8'h00, frame_cyc_reg, 1'b0} * {18'h00000, duty}) / 32'd100);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wcnt_reg <= 17'h00000;
    end else if (wcnt_reg >= {frame_cyc_reg, 1'b0} - 17'h00001) begin
      wcnt_reg <= 17'h00000;
    end else begin
      wcnt_reg <= wcnt_reg + 17'h00001;
    end
  end

  // Line driver: released, fault code, quiet, or normal data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_oe_o <= 1'b0;
      line_o    <= 1'b0;
      data_ok_o <= 1'b0;
    end else begin
      line_o    <= 1'b0;
      data_ok_o <= ~hiz & quiet_done & ~(pwm & coded);
      if (hiz) begin
        line_oe_o <= 1'b0;                        // R2 R5 R7 R8 R15 R16
      end else if (pwm && coded) begin
        line_oe_o <= wcnt_reg >= thr;             // R11 R12 R13
      end else if (!quiet_done) begin
        line_oe_o <= 1'b0;                        // R2
      end else begin
        line_oe_o <= normal_low_i;
      end
    end
  end

  // Status byte and SENT fields; self-test and double error kept out of the SENT fields
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_o     <= 8'h00;
      sent_diag_o <= 8'h00;
      sent_scn_o  <= 2'h0;
    end else begin
      fault_o              <= flt;                // R17
      sent_diag_o          <= 8'h00;
      sent_diag_o[DG_COIL] <= flt[FLT_COIL];      // R18
      sent_diag_o[DG_UV]   <= flt[FLT_UV];        // R18
      sent_diag_o[DG_OV]   <= flt[FLT_OV];        // R18
      sent_diag_o[DG_OT]   <= flt[FLT_OT];        // R18
      sent_diag_o[DG_OORL] <= flt[FLT_OORL];      // R18
      sent_diag_o[DG_OORH] <= flt[FLT_OORH];      // R18
      sent_scn_o[SCN_COIL] <= flt[FLT_COIL];      // R14
      sent_scn_o[SCN_ANY]  <= flt[FLT_UV] | flt[FLT_OV] | flt[FLT_OT] |
                              flt[FLT_OORL] | flt[FLT_OORH];  // R14
    end
  end
endmodule

/* File: tb/sfr_unit_checker.sv */
// Checker for sfr_unit: line release, byte maps, bus answer.
// Bound to sfr_unit; sees its ports only.
`timescale 1ns/1ps
module sfr_chk
  import sfr_pkg::*;
(
  input wire logic             clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, line_oe_o,
  input wire logic [7:0]       paddr_i, fault_o, sent_diag_o,
  input wire logic [31:0]      prdata_o,
  input wire logic [PIN_W-2:0] mon_i,
  input wire logic [1:0]       sent_scn_o
);
  // One clock domain; reset mutes all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Two sync flops, flag and output stage before release
  a_hv_release: assert property (mon_i[PIN_HV] [*5] |-> !line_oe_o)
    else $error("hv: line pulled");
  a_gnd_release: assert property (mon_i[PIN_GND] [*5] |-> !line_oe_o)
    else $error("gnd: line pulled");
  a_dbe_release: assert property (fault_o[FLT_EEDBE] [*3] |-> !line_oe_o)
    else $error("dbe: line pulled");
  a_lbist_release: assert property (fault_o[FLT_LBIST] [*3] |-> !line_oe_o)
    else $error("lbist: line pulled");
  a_diag_map: assert property (sent_diag_o == {2'h0, fault_o[2], fault_o[3], fault_o[4],
    fault_o[5], fault_o[6], fault_o[7]})
    else $error("diag byte wrong");
  a_scn_map: assert property (sent_scn_o == {|fault_o[7:3], fault_o[FLT_COIL]})
    else $error("scn bits wrong");
  a_bus_answer: assert property (pready_o == $past(psel_i && !penable_i))
    else $error("ready timing");
  a_eerd_pad: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == ADDR_EERD
    |=> prdata_o[31:30] == 2'h0 && prdata_o[27:26] == 2'h0)
    else $error("eerd pad bits");
  c_uv_code: cover property (fault_o[FLT_UV] && line_oe_o);
  c_lbist: cover property (fault_o[FLT_LBIST]);
  c_sbe: cover property (pready_o && prdata_o[EE_SBE]);
endmodule
bind sfr_unit sfr_chk u_chk (.*);

/* File: tb/sfr_ctrl_model.sv */
// Controller model: pulls the shared line low on request.
// Assumes a pull-up; the bench decides how long to hold.
`timescale 1ns/1ps
module sfr_ctrl (
  input  wire logic clk_i,   // Clock
  input  wire logic hold_i,  // Hold line low
  input  wire logic oe_i,    // Sensor pulls low
  output logic      line_o   // Wire level
);
  logic pull_reg;  // Own pull
  // Held past two frames by the bench
  always_ff @(posedge clk_i) begin
    pull_reg <= hold_i;
  end
  // Open drain: pull-up wins unless someone pulls
  assign line_o = !(pull_reg || oe_i);
endmodule

/* File: tb/tb_sfr_unit.sv */
// Bench for sfr_unit: fault flags, line codes, ECC reads, self-test.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ps
module tb_sensor_fault_response_unit
  import sfr_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, hold = 0, lbe = 0;
  logic        er, pready, pslverr, line, line_oe, muv = 0, mov = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, rd, ee = 0, prdata;
  logic [12:0] mon = 13'h0014;
  logic [15:0] lf = 16'hf660;
  logic [11:0] cfg = 0;
  int          error_cnt = 0, checks = 0, n;
  logic [12:0] tp [10] = '{13'h0002, 13'h0008, 13'h0100, 13'h0040, 13'h0200, 13'h0400,
                           13'h0042, 13'h0022, 13'h0082, 13'h0002};
  int          tl [10] = '{1200, 800, 1400, 600, 400, 200, 1200, 0, 0, 0};
  initial forever #20 clk_i = ~clk_i;
  sfr_unit #(.DIAG_CYCLES(200), .QUIET_CYCLES(50)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .mon_i(mon), .line_i(line), .line_o(), .line_oe_o(line_oe),
    .normal_low_i(1'b0), .ee_word_i(ee), .lbist_err_i(lbe), .fault_o(), .sent_diag_o(),
    .sent_scn_o(), .sync_start_o(), .data_ok_o());
  sfr_ctrl u_ctrl (.clk_i(clk_i), .hold_i(hold), .oe_i(line_oe), .line_o(line));
  task automatic test_done();
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("FAIL %0t seen %h exp %h", $time, s, x);
    end
  endtask
  // Setup, then access held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Model keeps both supply hystereses; flags are live levels
  task automatic step(input logic [12:0] p);
    logic lk;
    lk = cfg[11:9] inside {LOCK_A, LOCK_B, LOCK_C};
    muv = p[PIN_UVL] | (muv & !p[PIN_UVH]);
    mov = p[PIN_OVH] | (mov & !p[PIN_OVL]);
    mon <= p;
    repeat (20) @(posedge clk_i);
    apb(0, ADDR_STATUS, 0);
    chk(32'({rd[ST_PROG], rd[7:0]}), 32'({mov & !lk, (p[PIN_CLPH] | p[PIN_ADCH]) & !cfg[6],
      (p[PIN_CLPL] | p[PIN_ADCL]) & !cfg[6], p[PIN_OT] & !cfg[5], mov & lk & !cfg[4],
      muv & !cfg[3], p[PIN_COIL] & !cfg[7], 2'h0}));
  endtask
  // Hang guard, well past the expected run
  initial begin
    #(CLK_NS * 60000);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    step(13'h0002);
    step(13'h0000);
    step(13'h0004);
    apb(0, 8'h14, 0);
    chk({rd[31:1], er}, 32'h1);
    repeat (6) begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      cfg = lf[11:0] & 12'hffb;
      apb(1, ADDR_CFG, 32'(cfg));
      apb(0, ADDR_CFG, 0);
      chk(rd, 32'(cfg));
      step(13'h000c);
    end
    // Low time over one two-frame period shows the duty code
    foreach (tp[i]) begin
      // Self-test off: the coded low pulse would count as a request
      cfg = (i == 9) ? 12'h701 : 12'h700;
      apb(1, ADDR_CFG, 32'(cfg));
      step(13'h0014);
      step(tp[i]);
      n = 0;
      repeat (2000) begin
        @(posedge clk_i);
        n += int'(line_oe);
      end
      chk(n, tl[i]);
    end
    step(13'h0014);
    ee <= 32'h2;
    apb(0, ADDR_EERD, 0);
    chk(rd, 32'h1000_0000);
    ee <= 32'h6;
    repeat (5) @(posedge clk_i);
    apb(0, ADDR_EERD, 0);
    chk(32'(rd[31:26]), 32'h8);
    apb(0, ADDR_STATUS, 0);
    chk(32'(rd[7:0]), 32'h1);
    ee <= 32'h0;
    cfg = 0;
    apb(1, ADDR_CFG, 0);
    hold <= 1'b1;
    n = 0;
    do apb(0, ADDR_STATUS, 0); while (rd[ST_BUSY] !== 1'b1 && ++n < 1500);
    hold <= 1'b0;
    lbe <= 1'b1;
    repeat (150) @(posedge clk_i);
    lbe <= 1'b0;
    apb(0, ADDR_STATUS, 0);
    chk(32'(rd[ST_BUSY]), 32'h1);
    repeat (100) @(posedge clk_i);
    apb(0, ADDR_STATUS, 0);
    chk(32'({rd[ST_BUSY], rd[7:0]}), 32'h2);
    test_done();
  end
endmodule
